// File: hw/omc_regs.svh
// offsets, field positions and reset values of the module control logic
// assumes: included by the package only; the control module uses its macros without including it
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// two-wire device addresses, seven-bit form (0xa0 / 0xa2 with r/w bit clear)
`define OMC_SLA_ID 7'h50
`define OMC_SLA_DIAG 7'h51
// control_status_byte in the diagnostics page
`define OMC_CTRL_OFS 8'h6e
`define OMC_CTRL_SHUT_STATE 7
`define OMC_CTRL_SOFT_OFF 6
`define OMC_CTRL_FAULT 2
`define OMC_CTRL_LOS 1
// real-time monitor bytes in the diagnostics page, msb first
`define OMC_MON_BASE 8'h60
`define OMC_MON_LAST 8'h69
`define OMC_MON_BYTES 10
// laser power window limits, raw monitor units
`define OMC_PWR_MIN 16'h0100
`define OMC_PWR_MAX 16'hf000
// synchroniser reset value: lines idle high, shutoff seen as pulled up
`define OMC_SYNC_RST 4'hf

`endif

// File: hw/omc_pkg.sv
// types shared by the module control logic
// assumes: offsets and values come from omc_regs.svh
package omc_pkg;
  `include "omc_regs.svh"

  // two-wire slave states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_AACK = 4'b0010,
    S_OFS = 4'b0011,
    S_OACK = 4'b0100,
    S_WDAT = 4'b0101,
    S_WACK = 4'b0110,
    S_RDAT = 4'b0111,
    S_RACK = 4'b1000
  } omc_st_t;

  // real-time monitor words, in memory order
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] txpwr;
    logic [15:0] rxpwr;
  } omc_mon_t;

  // whole state of the control module
  typedef struct packed {
    omc_st_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic page;
    logic rw;
    logic nack;
    logic scl_d;
    logic sda_d;
    logic sda_o;
    logic sda_oe;
    logic soft_off;
    logic fault;
    logic laser_on;
    logic los;
  } omc_state_t;
endpackage : omc_pkg

// File: hw/omc_sync.sv
// two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to sys_clk; reset value set per bit
`timescale 1ns/1ps
module omc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by q

  // both stages reset to the idle level of the pins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : omc_sync

// File: hw/omc_ctrl.sv
// control and status logic of a pluggable optical module, two-wire slave
// assumes: pins asynchronous, srst is the power cycle / hot-plug reset
// What this block does
// - shutoff pin high turns transmitter off
// - shutoff reads as asserted from reset until the pin is sampled
// - control byte bit 6 sets, bit 7 reports
// - effective shutoff is software OR hardware
// - software shutoff clears on power cycle
// - laser fault raises fault output, disables laser
// - power outside window while lasing is a fault
// - fault latched until shutoff toggle or power
// - fault mirrored in control byte bit 2
// - signal loss output and bit 1 mirror
// - pages answer at 0xa0 and 0xa2
// - monitor values readable by host
`timescale 1ns/1ps
module omc_ctrl
  import omc_pkg::*;
#(
  parameter logic [15:0] PWR_MIN = `OMC_PWR_MIN,
  parameter logic [15:0] PWR_MAX = `OMC_PWR_MAX
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic tx_shutoff_pin,
  input wire logic los_pin,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire omc_mon_t mon,
  output logic laser_on,
  output logic laser_fault,
  output logic receive_signal_lost
);
  omc_state_t q_r; // registered state
  omc_state_t q_nxt; // next state
  logic [3:0] pins_s; // synchronised pins
  logic shut_s, los_s, scl_s, sda_s;
  logic [7:0] id_mem [0:255]; // identification page
  logic [7:0] diag_mem [0:255]; // diagnostics page, user bytes
  logic [9:0][7:0] mon_b; // monitor words as bytes
  logic [7:0] rd; // byte at the pointer
  logic [7:0] ctrl_byte; // live control_status_byte
  logic [3:0] mon_idx;
  logic start, stop, rise, fall, full, eff_off, pwr_bad;
  logic wr_en; // user byte write strobe
  integer i;

  // pull-up level: shutoff bit resets high until the pin is seen
  omc_sync #(.W(4), .RST(`OMC_SYNC_RST)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d({tx_shutoff_pin, los_pin, scl_i, sda_i}),
    .q(pins_s)
  );
  assign {shut_s, los_s, scl_s, sda_s} = pins_s;

  // line events from the synchronised levels
  assign start = scl_s && q_r.scl_d && q_r.sda_d && !sda_s;
  assign stop = scl_s && q_r.scl_d && !q_r.sda_d && sda_s;
  assign rise = scl_s && !q_r.scl_d;
  assign fall = !scl_s && q_r.scl_d;
  assign full = (q_r.bitc == 4'h8);
  // or of the two shutoff sources
  assign eff_off = shut_s || q_r.soft_off;
  // outside the permitted window either way
  assign pwr_bad = (mon.txpwr < PWR_MIN) || (mon.txpwr > PWR_MAX);
  assign mon_b = mon;
  assign mon_idx = 4'(q_r.ptr - `OMC_MON_BASE);

  // status mirror, unused bits read zero
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[`OMC_CTRL_SHUT_STATE] = shut_s;
    ctrl_byte[`OMC_CTRL_SOFT_OFF] = q_r.soft_off;
    ctrl_byte[`OMC_CTRL_FAULT] = q_r.fault;
    ctrl_byte[`OMC_CTRL_LOS] = q_r.los;
  end

  // read mux; live values override the stored diagnostics bytes
  always_comb begin
    rd = q_r.page ? diag_mem[q_r.ptr] : id_mem[q_r.ptr];
    if (q_r.page) begin
      if (q_r.ptr == `OMC_CTRL_OFS) begin
        rd = ctrl_byte;
      // monitor words straight from the converters
      end else if (q_r.ptr >= `OMC_MON_BASE && q_r.ptr <= `OMC_MON_LAST) begin
        rd = mon_b[4'(`OMC_MON_BYTES - 1) - mon_idx];
      end
    end
  end

  // next-state logic: two-wire slave plus laser control
  always_comb begin
    q_nxt = q_r;
    wr_en = 1'b0;
    q_nxt.scl_d = scl_s;
    q_nxt.sda_d = sda_s;
    q_nxt.sda_o = 1'b0; // open drain: only ever pulls low
    if (start) begin
      // repeated start lands here too
      q_nxt.st = S_ADDR;
      q_nxt.bitc = 4'h0;
      q_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      q_nxt.st = S_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else if (rise) begin
      // data is sampled on the rising clock edge
      unique case (q_r.st)
        S_ADDR, S_OFS, S_WDAT: begin
          q_nxt.sh = {q_r.sh[6:0], sda_s};
          q_nxt.bitc = q_r.bitc + 4'h1;
        end
        S_RDAT: q_nxt.bitc = q_r.bitc + 4'h1;
        S_RACK: q_nxt.nack = sda_s;
        S_IDLE, S_AACK, S_OACK, S_WACK: ;
      endcase
    end else if (fall) begin
      // the line is changed only while the clock is low
      unique case (q_r.st)
        S_ADDR: if (full) begin
          // answer only the two page addresses
          if (q_r.sh[7:1] == `OMC_SLA_ID || q_r.sh[7:1] == `OMC_SLA_DIAG) begin
            q_nxt.st = S_AACK;
            q_nxt.sda_oe = 1'b1;
            q_nxt.page = q_r.sh[1];
            q_nxt.rw = q_r.sh[0];
          end else begin
            q_nxt.st = S_IDLE; // someone else's address
          end
        end
        S_OFS: if (full) begin
          q_nxt.ptr = q_r.sh;
          q_nxt.st = S_OACK;
          q_nxt.sda_oe = 1'b1;
        end
        S_WDAT: if (full) begin
          // identification page is read-only but still acknowledged
          if (q_r.page) begin
            if (q_r.ptr == `OMC_CTRL_OFS) begin
              // host sets or clears the software shutoff
              q_nxt.soft_off = q_r.sh[`OMC_CTRL_SOFT_OFF];
            end else if (q_r.ptr < `OMC_MON_BASE || q_r.ptr > `OMC_MON_LAST) begin
              wr_en = 1'b1;
            end
          end
          q_nxt.ptr = q_r.ptr + 8'h01; // wraps inside the page
          q_nxt.st = S_WACK;
          q_nxt.sda_oe = 1'b1;
        end
        S_AACK, S_OACK, S_WACK: begin
          q_nxt.bitc = 4'h0;
          q_nxt.sda_oe = 1'b0;
          if (q_r.st == S_AACK && q_r.rw) begin
            q_nxt.st = S_RDAT;
            q_nxt.sh = rd;
            q_nxt.sda_oe = !rd[7];
          end else begin
            q_nxt.st = (q_r.st == S_AACK) ? S_OFS : S_WDAT;
          end
        end
        S_RDAT: if (full) begin
          q_nxt.st = S_RACK;
          q_nxt.sda_oe = 1'b0;
          q_nxt.ptr = q_r.ptr + 8'h01;
        end else begin
          q_nxt.sh = {q_r.sh[6:0], 1'b0};
          q_nxt.sda_oe = !q_r.sh[6];
        end
        S_RACK: begin
          q_nxt.bitc = 4'h0;
          // master nack ends the read; wait for stop
          if (q_r.nack) begin
            q_nxt.st = S_IDLE;
          end else begin
            q_nxt.st = S_RDAT;
            q_nxt.sh = rd;
            q_nxt.sda_oe = !rd[7];
          end
        end
        S_IDLE: ;
      endcase
    end

    // shutoff high clears the latch, laser waits for low
    if (eff_off) begin
      q_nxt.fault = 1'b0;
    // a bad power reading while lasing latches a fault
    end else if (q_r.laser_on && pwr_bad) begin
      q_nxt.fault = 1'b1;
    end
    // laser off while shut off or faulted
    q_nxt.laser_on = !eff_off && !q_nxt.fault;
    q_nxt.los = los_s; // loss of signal follows the receiver
  end

  // register the whole state; reset clears the software shutoff
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.st <= S_IDLE;
      q_r.scl_d <= 1'b1;
      q_r.sda_d <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // identification page powers up blank; factory data is loaded by other means
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      id_mem[i] = 8'h00;
    end
  end

  // user bytes of the diagnostics page; blanked by the power cycle reset
  // so that this process is the only writer of the array
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int k = 0; k < 256; k++) begin
        diag_mem[k] <= 8'h00;
      end
    end else if (wr_en) begin
      diag_mem[q_r.ptr] <= q_r.sh;
    end
  end

  assign sda_o = q_r.sda_o;
  assign sda_oe = q_r.sda_oe;
  assign laser_on = q_r.laser_on;
  assign laser_fault = q_r.fault;
  assign receive_signal_lost = q_r.los;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_toggle_high;
    laser_fault && eff_off;
  endsequence

  a_shutoff_laser_off: assert property (shut_s |=> !laser_on)
    else $error("laser on while shutoff pin high");
  a_release_safe: assert property ($fell(srst) |-> !laser_on && !q_r.soft_off)
    else $error("laser or soft shutoff wrong after reset");
  a_soft_write: assert property (wr_en |-> q_r.ptr != `OMC_CTRL_OFS)
    else $error("control byte written into memory");
  a_soft_or: assert property (q_r.soft_off |=> !laser_on)
    else $error("soft shutoff ignored");
  a_fault_set: assert property (laser_on && pwr_bad && !eff_off |=> laser_fault && !laser_on)
    else $error("bad power did not latch fault");
  a_fault_hold: assert property (laser_fault && !eff_off |=> laser_fault)
    else $error("fault cleared without toggle");
  a_toggle_clear: assert property (s_toggle_high |=> !laser_fault)
    else $error("shutoff high did not clear fault");
  a_ctrl_mirror: assert property (q_r.page && q_r.ptr == `OMC_CTRL_OFS |->
      rd[2] == laser_fault && rd[1] == receive_signal_lost)
    else $error("control byte mirror wrong");
  a_los_follow: assert property (los_s |=> receive_signal_lost)
    else $error("signal loss not reported");
  a_addr_ack: assert property (fall && q_r.st == S_ADDR && full &&
      q_r.sh[7:1] == `OMC_SLA_DIAG |=> sda_oe ##1 q_r.page)
    else $error("diagnostics address not acknowledged");
  a_mon_read: assert property (q_r.page && q_r.ptr == `OMC_MON_BASE |->
      rd == mon.temp[15:8])
    else $error("temperature byte wrong");
endmodule : omc_ctrl

// File: sim/omc_host_model.sv
// two-wire master standing in for the host board controller
// assumes: sys_clk is the design clock; the module pulls sda low via sda_oe
`timescale 1ns/1ps
module omc_host_model (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl_i,
  output logic sda_i
);
  logic scl_r = 1'b1; // master clock level, idle high
  logic sda_m = 1'b1; // master data, released means pulled up
  // open-drain wire: pull-up unless someone pulls low
  assign scl_i = scl_r;
  assign sda_i = sda_m & !sda_oe;
  // inputs only move on the falling clock edge
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // one bit slot: data set mid-low, sampled mid-way through the high phase
  task automatic xbit(input logic b, output logic r);
    wt(5);
    sda_m = b;
    wt(5);
    scl_r = 1'b1;
    wt(5);
    r = sda_i;
    wt(5);
    scl_r = 1'b0;
  endtask : xbit
  // start, also used as repeated start after an ack slot
  task automatic start;
    wt(5);
    sda_m = 1'b1;
    wt(5);
    scl_r = 1'b1;
    wt(10);
    sda_m = 1'b0;
    wt(10);
    scl_r = 1'b0;
  endtask : start
  task automatic stop;
    wt(5);
    sda_m = 1'b0;
    wt(5);
    scl_r = 1'b1;
    wt(10);
    sda_m = 1'b1;
    wt(10);
  endtask : stop
  // eight bits msb first, then the ack slot; ack low means taken
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(1'b1, ack);
  endtask : xbyte
  task automatic wr(input logic [7:0] dev, ofs, dat, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xbyte(dev, q, a0);
    xbyte(ofs, q, a1);
    xbyte(dat, q, a2);
    stop();
    ack = a0 | a1 | a2;
  endtask : wr
  // random read of one byte, last byte nacked by the master
  task automatic rd(input logic [7:0] dev, ofs, output logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xbyte(dev, q, a0);
    xbyte(ofs, q, a1);
    start();
    xbyte(dev | 8'h01, q, a2);
    xbyte(8'hff, d, a3);
    stop();
    ack = a0 | a1 | a2;
  endtask : rd
  // two-byte random read: master acks the first byte, nacks the second
  task automatic rd2(input logic [7:0] dev, ofs, output logic [7:0] d0, d1,
      output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, a3, a4;
    start();
    xbyte(dev, q, a0);
    xbyte(ofs, q, a1);
    start();
    xbyte(dev | 8'h01, q, a2);
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d0[i]);
    end
    xbit(1'b0, a3);
    xbyte(8'hff, d1, a4);
    stop();
    ack = a0 | a1 | a2;
  endtask : rd2
endmodule : omc_host_model

// File: sim/test_omc_ctrl.sv
// self-checking bench of the module control logic
// assumes: host model drives the two-wire pins; shutoff pin has a pull-up
`timescale 1ns/1ps
module test_omc_ctrl;
  import omc_pkg::*;
  logic sys_clk;
  logic srst;
  logic pin_en; // host drives the shutoff pin
  logic pin_val;
  logic los_pin;
  omc_mon_t mon;
  logic scl_i, sda_i, sda_o, sda_oe, laser_on, laser_fault, receive_signal_lost;
  logic [7:0] rdat;
  logic [7:0] rdat2;
  logic [79:0] mon_exp; // monitor bytes in memory order, msb first
  logic ack;
  int failures = 0;
  int n_checks = 0;
  // pull-up: undriven pin reads high
  wire logic tx_shutoff_pin = pin_en ? pin_val : 1'b1;
  omc_ctrl dut_u (.sys_clk(sys_clk), .srst(srst), .tx_shutoff_pin(tx_shutoff_pin),
    .los_pin(los_pin), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .mon(mon), .laser_on(laser_on), .laser_fault(laser_fault),
    .receive_signal_lost(receive_signal_lost));
  omc_host_model host_u (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_byte
  // read one byte over the wire and compare with its ack
  task automatic rdb(input logic [7:0] dev, ofs, exp);
    host_u.rd(dev, ofs, rdat, ack);
    chk_bit(ack, 1'b0);
    chk_byte(rdat, exp);
  endtask : rdb
  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard, well above the whole sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    pin_en = 1'b0;
    pin_val = 1'b0;
    los_pin = 1'b0;
    mon = '{16'h1234, 16'h5678, 16'h9abc, `OMC_PWR_MIN, 16'hdef0};
    host_u.wt(5);
    srst = 1'b0;
    host_u.wt(10);
    chk_bit(laser_on, 1'b0);
    rdb(8'ha2, `OMC_CTRL_OFS, 8'h80);
    // host ties the shutoff pin low
    pin_en = 1'b1;
    host_u.wt(5);
    chk_bit(laser_on, 1'b1);
    pin_val = 1'b1;
    host_u.wt(5);
    chk_bit(laser_on, 1'b0);
    pin_val = 1'b0;
    // only the soft shutoff bit is writable
    host_u.wr(8'ha2, `OMC_CTRL_OFS, 8'hff, ack);
    chk_bit(ack, 1'b0);
    host_u.wt(2);
    chk_bit(laser_on, 1'b0);
    rdb(8'ha2, `OMC_CTRL_OFS, 8'h40);
    // second power cycle mid-run clears the soft bit
    srst = 1'b1;
    host_u.wt(5);
    srst = 1'b0;
    host_u.wt(10);
    chk_bit(laser_on, 1'b1);
    rdb(8'ha2, `OMC_CTRL_OFS, 8'h00);
    host_u.wr(8'ha4, 8'h00, 8'h55, ack);
    chk_bit(ack, 1'b1);
    host_u.wr(8'ha0, 8'h10, 8'h55, ack);
    chk_bit(ack, 1'b0);
    rdb(8'ha0, 8'h10, 8'h00);
    rdb(8'ha2, 8'h60, 8'h12);
    rdb(8'ha2, 8'h69, 8'hf0);
    // user byte of the diagnostics page keeps what is written
    host_u.wr(8'ha2, 8'h80, 8'h5a, ack);
    chk_bit(ack, 1'b0);
    rdb(8'ha2, 8'h80, 8'h5a);
    // fresh monitor values, every byte read back; txpwr stays in the window
    mon = '{16'ha1b2, 16'hc3d4, 16'he5f6, 16'h0a0b, 16'h1c2d};
    mon_exp = 80'ha1b2_c3d4_e5f6_0a0b_1c2d;
    for (int j = 0; j < 10; j++) begin
      rdb(8'ha2, 8'h60 + 8'(j), mon_exp[79 - 8 * j -: 8]);
    end
    // monitor bytes ignore writes
    host_u.wr(8'ha2, 8'h60, 8'h00, ack);
    chk_bit(ack, 1'b0);
    rdb(8'ha2, 8'h60, 8'ha1);
    // acked first byte moves the pointer on to the next one
    host_u.rd2(8'ha2, 8'h68, rdat, rdat2, ack);
    chk_bit(ack, 1'b0);
    chk_byte(rdat, 8'h1c);
    chk_byte(rdat2, 8'h2d);
    chk_bit(sda_o, 1'b0);
    los_pin = 1'b1;
    host_u.wt(5);
    chk_bit(receive_signal_lost, 1'b1);
    rdb(8'ha2, `OMC_CTRL_OFS, 8'h02);
    los_pin = 1'b0;
    // just below and just above the power window
    for (int i = 0; i < 2; i++) begin
      mon.txpwr = i ? `OMC_PWR_MAX + 16'h0001 : `OMC_PWR_MIN - 16'h0001;
      host_u.wt(3);
      chk_bit(laser_fault, 1'b1);
      chk_bit(laser_on, 1'b0);
      mon.txpwr = `OMC_PWR_MIN;
      rdb(8'ha2, `OMC_CTRL_OFS, 8'h04);
      chk_bit(laser_fault, 1'b1);
      pin_val = 1'b1;
      host_u.wt(5);
      chk_bit(laser_fault, 1'b0);
      chk_bit(laser_on, 1'b0);
      pin_val = 1'b0;
      host_u.wt(5);
      chk_bit(laser_on, 1'b1);
    end
    // a power cycle clears a latched fault as well
    mon.txpwr = `OMC_PWR_MAX + 16'h0001;
    host_u.wt(3);
    chk_bit(laser_fault, 1'b1);
    mon.txpwr = `OMC_PWR_MIN;
    srst = 1'b1;
    host_u.wt(5);
    srst = 1'b0;
    host_u.wt(2);
    chk_bit(laser_fault, 1'b0);
    chk_bit(laser_on, 1'b0);
    host_u.wt(10);
    chk_bit(laser_on, 1'b1);
    print_verdict();
  end
endmodule : test_omc_ctrl
